/* File: core/lbw_pkg.sv */
// constants, register map and state type for the local bus wait controller
package lbw_pkg;
   // apb byte offsets of the three control registers
   localparam logic [11:0] LBW_OFF_EXT_CTRL = 12'h000;
   localparam logic [11:0] LBW_OFF_WAIT_LOW = 12'h004;
   localparam logic [11:0] LBW_OFF_WAIT_HIGH = 12'h008;
   // reset values
   localparam logic [7:0] LBW_EXT_CTRL_RESET = 8'h20;
   localparam logic [7:0] LBW_WAIT_LOW_RESET = 8'hAA;
   localparam logic [15:0] LBW_WAIT_HIGH_RESET = 16'hAAAA;
   // memory_extension_control fields
   localparam int LBW_ROM_FETCH_SPEED_BIT = 7;
   localparam int LBW_ADDRESS_WAIT_ENABLE_BIT = 5;
   localparam int LBW_MODE_LSB = 0;
   localparam int LBW_MODE_W = 4;
   // extension mode codes
   localparam logic [3:0] LBW_MODE_SINGLE = 4'h0;
   localparam logic [3:0] LBW_MODE_256B = 4'h3;
   localparam logic [3:0] LBW_MODE_1K = 4'h4;
   localparam logic [3:0] LBW_MODE_4K = 4'h5;
   localparam logic [3:0] LBW_MODE_16K = 4'h6;
   localparam logic [3:0] LBW_MODE_64K = 4'h7;
   localparam logic [3:0] LBW_MODE_256K = 4'h8;
   localparam logic [3:0] LBW_MODE_1M = 4'h9;
   // two-bit wait field codes
   localparam logic [1:0] LBW_WAIT_0 = 2'h0;
   localparam logic [1:0] LBW_WAIT_1 = 2'h1;
   localparam logic [1:0] LBW_WAIT_2 = 2'h2;
   localparam logic [1:0] LBW_WAIT_PIN = 2'h3;
   // address layout
   localparam int LBW_ADDR_W = 20;
   localparam int LBW_UPPER_W = 12;
   localparam int LBW_FIELD_W = 2;
   // bus cycle states
   typedef enum logic [2:0] {
      LBW_ST_IDLE,
      LBW_ST_ADDR,
      LBW_ST_AWAIT,
      LBW_ST_STROBE,
      LBW_ST_HOLD
   } lbw_state_type;
endpackage

/* File: core/lbw_wait_sel.sv */
// registered per-space wait field selection
module lbw_wait_sel
   import lbw_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // access address and wait registers
   input wire logic [LBW_ADDR_W-1:0] addr,
   input wire logic [7:0] pwc_low,
   input wire logic [15:0] pwc_high,
   // selected field
   output logic [1:0] wait_code
);
   logic [1:0] next_wait_code;
   logic [1:0] idx;

   always_comb begin
      idx = 2'h0;
      next_wait_code = LBW_WAIT_0;
      if (addr[19:16] == 4'h0) begin
         // four 16-kbyte spaces below 10000h
         idx = addr[15:14];
         next_wait_code = pwc_low[idx*LBW_FIELD_W +: LBW_FIELD_W];
      end else begin
         // 64k, 128k, 256k and 512k spaces from 10000h upward
         if (addr[19]) begin
            idx = 2'h3;
         end else if (addr[18]) begin
            idx = 2'h2;
         end else if (addr[17]) begin
            idx = 2'h1;
         end
         next_wait_code = pwc_high[idx*LBW_FIELD_W +: LBW_FIELD_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_code <= LBW_WAIT_2;
      end else begin
         wait_code <= next_wait_code;
      end
   end
endmodule // lbw_wait_sel

/* File: core/lbw_local_bus.sv */
// local bus interface with address and access wait control, apb registers
//
// Design decisions made here: the APB register port and the placing of the registers.
module lbw_local_bus
   import lbw_pkg::*;
#(
   parameter bit NO_INTERNAL_ROM = 1'b0
)(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu access request
   input wire logic cpu_req,
   input wire logic [LBW_ADDR_W-1:0] cpu_addr,
   input wire logic cpu_write,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_internal,
   input wire logic cpu_rom,
   output logic cpu_done,
   output logic [7:0] cpu_rdata,
   // external bus pins
   output logic address_strobe,
   output logic read_strobe_n,
   output logic write_strobe_n,
   input wire logic [7:0] low_multiplexed_bus_in,
   output logic [7:0] low_multiplexed_bus_out,
   output logic low_multiplexed_bus_oe,
   output logic [LBW_UPPER_W-1:0] upper_address_lines,
   output logic [LBW_UPPER_W-1:0] upper_address_bus_en,
   output logic port_pins_bus_sel,
   input wire logic wait_pin_n
);
   // registers and state
   // the three control registers and their next values
   logic [7:0] memory_extension_control, next_ext_ctrl;
   logic [7:0] wait_control_low_spaces, next_wait_low;
   logic [15:0] wait_control_high_spaces, next_wait_high;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   lbw_state_type state, next_state;
   logic [1:0] wcnt, next_wcnt;
   logic [LBW_ADDR_W-1:0] acc_addr, next_acc_addr;
   logic acc_write, next_acc_write, acc_quiet, next_acc_quiet;
   logic [7:0] acc_wdata, next_acc_wdata;
   logic next_cpu_done, next_addr_strobe, next_rd_n, next_wr_n, next_ad_oe, next_bus_sel;
   logic [7:0] next_cpu_rdata, next_ad_out;
   logic [LBW_UPPER_W-1:0] next_upper, next_upper_en;
   logic [1:0] wait_code;
   logic [3:0] mode;
   logic fast_rom, addr_wait_en, bus_active, apb_access, apb_wr;
   logic [LBW_ADDR_W-1:0] size_mask;

   // address bits kept by each extension size
   function automatic logic [LBW_ADDR_W-1:0] mode_mask(input logic [3:0] m);
      logic [LBW_ADDR_W-1:0] r;
      r = 20'h000FF;
      if (m == LBW_MODE_1K) begin
         r = 20'h003FF;
      end else if (m == LBW_MODE_4K) begin
         r = 20'h00FFF;
      end else if (m == LBW_MODE_16K) begin
         r = 20'h03FFF;
      end else if (m == LBW_MODE_64K) begin
         r = 20'h0FFFF;
      end else if (m == LBW_MODE_256K) begin
         r = 20'h3FFFF;
      end else if (m == LBW_MODE_1M) begin
         r = 20'hFFFFF;
      end
      return r;
   endfunction

   lbw_wait_sel u_wait_sel (
      .pclk(pclk),
      .presetn(presetn),
      .addr(acc_addr),
      .pwc_low(wait_control_low_spaces),
      .pwc_high(wait_control_high_spaces),
      .wait_code(wait_code)
   );

   // romless part runs small modes as 64k, single-chip too
   always_comb begin
      mode = memory_extension_control[LBW_MODE_LSB +: LBW_MODE_W];
      if (NO_INTERNAL_ROM && mode != LBW_MODE_256K && mode != LBW_MODE_1M) begin
         mode = LBW_MODE_64K;
      end
      bus_active = NO_INTERNAL_ROM || (mode != LBW_MODE_SINGLE);
      size_mask = mode_mask(mode);
      fast_rom = memory_extension_control[LBW_ROM_FETCH_SPEED_BIT];
      addr_wait_en = memory_extension_control[LBW_ADDRESS_WAIT_ENABLE_BIT];
   end

   // apb: answer one cycle into the access phase
   always_comb begin
      apb_access = psel && penable && !pready;
      apb_wr = psel && penable && pready && pwrite && !pslverr;
      next_pready = apb_access;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      next_ext_ctrl = memory_extension_control;
      next_wait_low = wait_control_low_spaces;
      next_wait_high = wait_control_high_spaces;
      if (apb_access) begin
         if (paddr == LBW_OFF_EXT_CTRL) begin
            next_prdata = {24'h00_0000, memory_extension_control};
            next_pslverr = pwrite && !pstrb[0];
         end else if (paddr == LBW_OFF_WAIT_LOW) begin
            next_prdata = {24'h00_0000, wait_control_low_spaces};
            next_pslverr = pwrite && !pstrb[0];
         end else if (paddr == LBW_OFF_WAIT_HIGH) begin
            next_prdata = {16'h0000, wait_control_high_spaces};
            next_pslverr = pwrite && (pstrb[1:0] != 2'h3);
         end else begin
            next_pslverr = 1'b1;
         end
      end
      // a write lands only at the edge that samples pready high
      if (apb_wr) begin
         if (paddr == LBW_OFF_EXT_CTRL) begin
            next_ext_ctrl = pwdata[7:0];
         end else if (paddr == LBW_OFF_WAIT_LOW) begin
            next_wait_low = pwdata[7:0];
         end else if (paddr == LBW_OFF_WAIT_HIGH) begin
            // upper byte stored as written; software keeps it at AAh
            next_wait_high = pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         memory_extension_control <= LBW_EXT_CTRL_RESET;
         wait_control_low_spaces <= LBW_WAIT_LOW_RESET;
         wait_control_high_spaces <= LBW_WAIT_HIGH_RESET;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         memory_extension_control <= next_ext_ctrl;
         wait_control_low_spaces <= next_wait_low;
         wait_control_high_spaces <= next_wait_high;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // bus cycle engine
   always_comb begin
      next_state = state;
      next_wcnt = wcnt;
      next_acc_addr = acc_addr;
      next_acc_write = acc_write;
      next_acc_wdata = acc_wdata;
      next_acc_quiet = acc_quiet;
      next_cpu_done = 1'b0;
      next_cpu_rdata = cpu_rdata;
      next_addr_strobe = 1'b0;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_ad_out = low_multiplexed_bus_out;
      next_ad_oe = 1'b0;
      next_upper = upper_address_lines;
      next_bus_sel = bus_active;
      next_upper_en = bus_active ? size_mask[LBW_ADDR_W-1:8] : 12'h000;
      case (state)
         LBW_ST_IDLE: begin
            if (cpu_req && !cpu_done) begin
               if (cpu_internal && !(cpu_rom && !fast_rom)) begin
                  // internal hit: no strobes, address held, bus floats
                  next_cpu_done = 1'b1;
               end else begin
                  next_acc_addr = cpu_addr;
                  next_acc_write = cpu_write;
                  next_acc_wdata = cpu_wdata;
                  // rom on the slow cycle keeps external timing but stays off the pins
                  next_acc_quiet = cpu_internal || !bus_active;
                  next_state = LBW_ST_ADDR;
                  if (!(cpu_internal || !bus_active)) begin
                     next_addr_strobe = 1'b1;
                     next_ad_out = cpu_addr[7:0];
                     next_ad_oe = 1'b1;
                     next_upper = cpu_addr[LBW_ADDR_W-1:8] & size_mask[LBW_ADDR_W-1:8];
                  end
               end
            end
         end
         LBW_ST_ADDR: begin
            next_wcnt = 2'h0;
            // decode time: one extra cycle of strobe high before read or write
            if (addr_wait_en) begin
               next_state = LBW_ST_AWAIT;
               next_addr_strobe = !acc_quiet;
               next_ad_oe = !acc_quiet;
            end else begin
               next_state = LBW_ST_STROBE;
               next_rd_n = acc_quiet || acc_write;
               next_wr_n = acc_quiet || !acc_write;
               next_ad_out = acc_wdata;
               next_ad_oe = !acc_quiet && acc_write;
            end
         end
         LBW_ST_AWAIT: begin
            next_state = LBW_ST_STROBE;
            next_rd_n = acc_quiet || acc_write;
            next_wr_n = acc_quiet || !acc_write;
            next_ad_out = acc_wdata;
            next_ad_oe = !acc_quiet && acc_write;
         end
         LBW_ST_STROBE: begin
            next_rd_n = read_strobe_n;
            next_wr_n = write_strobe_n;
            next_ad_oe = low_multiplexed_bus_oe;
            // pin mode waits while the pin is low; on rom space it can hang
            if (wait_code == LBW_WAIT_PIN) begin
               if (wait_pin_n) begin
                  next_state = LBW_ST_HOLD;
               end
            end else if (wcnt == wait_code) begin
               next_state = LBW_ST_HOLD;
            end else begin
               next_wcnt = wcnt + 2'h1;
            end
            if (next_state == LBW_ST_HOLD) begin
               next_rd_n = 1'b1;
               next_wr_n = 1'b1;
               next_ad_oe = 1'b0;
               next_cpu_done = 1'b1;
               next_cpu_rdata = acc_quiet ? cpu_rdata : low_multiplexed_bus_in;
            end
         end
         LBW_ST_HOLD: begin
            next_state = LBW_ST_IDLE;
         end
         default: begin
            next_state = LBW_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LBW_ST_IDLE;
         wcnt <= 2'h0;
         acc_addr <= 20'h00000;
         acc_write <= 1'b0;
         acc_wdata <= 8'h00;
         acc_quiet <= 1'b0;
         cpu_done <= 1'b0;
         cpu_rdata <= 8'h00;
         address_strobe <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         low_multiplexed_bus_out <= 8'h00;
         low_multiplexed_bus_oe <= 1'b0;
         upper_address_lines <= 12'h000;
         upper_address_bus_en <= 12'h000;
         port_pins_bus_sel <= 1'b0;
      end else begin
         state <= next_state;
         wcnt <= next_wcnt;
         acc_addr <= next_acc_addr;
         acc_write <= next_acc_write;
         acc_wdata <= next_acc_wdata;
         acc_quiet <= next_acc_quiet;
         cpu_done <= next_cpu_done;
         cpu_rdata <= next_cpu_rdata;
         address_strobe <= next_addr_strobe;
         read_strobe_n <= next_rd_n;
         write_strobe_n <= next_wr_n;
         low_multiplexed_bus_out <= next_ad_out;
         low_multiplexed_bus_oe <= next_ad_oe;
         upper_address_lines <= next_upper;
         upper_address_bus_en <= next_upper_en;
         port_pins_bus_sel <= next_bus_sel;
      end
   end

   // checks
   // strobe seen high at the take's next edge, once more in the wait, then low
   a_addr_wait_stretch: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(address_strobe) && addr_wait_en |=> address_strobe ##1 !address_strobe)
      else $error("address wait did not stretch strobe by one cycle");
   a_no_addr_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(address_strobe) && !addr_wait_en |=> !address_strobe)
      else $error("strobe stretched without address wait");
   a_two_waits: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(read_strobe_n) && wait_code == LBW_WAIT_2 |-> !read_strobe_n [*3] ##1 read_strobe_n)
      else $error("two access waits not three low cycles");
   a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(write_strobe_n) && wait_code == LBW_WAIT_0 |=> write_strobe_n)
      else $error("zero wait write strobe not one cycle");
   a_internal_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      state == LBW_ST_IDLE && cpu_req && !cpu_done && cpu_internal && !cpu_rom
      |=> cpu_done && read_strobe_n && write_strobe_n && !address_strobe
      && !low_multiplexed_bus_oe && $stable(upper_address_lines))
      else $error("internal access reached the pins");
   a_upper_mask: assert property (@(posedge pclk) disable iff (!presetn)
      address_strobe |-> (upper_address_lines & ~upper_address_bus_en) == 12'h000)
      else $error("upper address beyond extension size driven");
   a_wait_low_write: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && !pslverr && paddr == LBW_OFF_WAIT_LOW
      |=> wait_control_low_spaces == $past(pwdata[7:0]))
      else $error("low wait register write lost");
   a_wait_high_narrow: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && pwrite && paddr == LBW_OFF_WAIT_HIGH && pstrb[1:0] != 2'h3
      |=> pslverr ##1 $stable(wait_control_high_spaces))
      else $error("narrow write reached high wait register");
   a_pins_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !port_pins_bus_sel |-> read_strobe_n && write_strobe_n && !low_multiplexed_bus_oe)
      else $error("bus pins driven while ports");
endmodule // lbw_local_bus

/* File: tb/lbw_ext_mem.sv */
// external byte memory model on the multiplexed local bus
module lbw_ext_mem (
   // bus pins
   input wire logic pclk,
   input wire logic address_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] bus_out,
   output logic [7:0] bus_in,
   // wait control
   input wire logic [3:0] hold_cycles,
   output logic wait_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] lat_addr = 8'h00;
   logic [7:0] last = 8'h00;
   logic [3:0] cnt = 4'h0;
   initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
   // low address taken at each edge while the strobe is high; the design swaps
   // address for data at the very edge that drops the strobe
   always @(posedge pclk) if (address_strobe) lat_addr <= bus_out;
   // released bus shows the inverse, so a late sample cannot match by luck
   assign bus_in = read_strobe_n ? ~last : mem[lat_addr];
   always @(posedge read_strobe_n) last <= mem[lat_addr];
   always @(posedge write_strobe_n) mem[lat_addr] <= bus_out;
   // slow device: holds wait low for hold_cycles of each strobe
   always @(posedge pclk) cnt <= (read_strobe_n && write_strobe_n) ? 4'h0 : cnt + 4'h1;
   assign wait_pin_n = (read_strobe_n && write_strobe_n) || (cnt >= hold_cycles);
endmodule // lbw_ext_mem

/* File: tb/lbw_local_bus_bench.sv */
// self-checking bench for the local bus wait controller
module lbw_local_bus_bench import lbw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0, hold_cycles = 4'h0;
   logic cpu_req = 1'b0, cpu_write = 1'b0, cpu_internal = 1'b0, cpu_rom = 1'b0, cpu_done;
   logic [LBW_ADDR_W-1:0] cpu_addr = '0;
   logic [7:0] cpu_wdata = 8'h00, cpu_rdata, bus_in, bus_out;
   logic address_strobe, read_strobe_n, write_strobe_n, bus_oe, port_pins_bus_sel, wait_pin_n;
   logic romless_bus_sel;
   logic [LBW_UPPER_W-1:0] upper_address_lines, upper_address_bus_en, up_seen, romless_bus_en;
   int num_errors = 0, n_tests = 0, cycles = 0, n_addr_stb, n_low, n_oe, n_cyc;
   always #2 pclk = ~pclk;
   lbw_local_bus lbw_local_bus_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
      .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
      .cpu_internal(cpu_internal), .cpu_rom(cpu_rom), .cpu_done(cpu_done),
      .cpu_rdata(cpu_rdata), .address_strobe(address_strobe), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .low_multiplexed_bus_in(bus_in),
      .low_multiplexed_bus_out(bus_out), .low_multiplexed_bus_oe(bus_oe),
      .upper_address_lines(upper_address_lines), .upper_address_bus_en(upper_address_bus_en),
      .port_pins_bus_sel(port_pins_bus_sel), .wait_pin_n(wait_pin_n));
   lbw_ext_mem lbw_ext_mem_inst (.pclk(pclk), .address_strobe(address_strobe),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .bus_out(bus_out),
      .bus_in(bus_in), .hold_cycles(hold_cycles), .wait_pin_n(wait_pin_n));
   // romless variant shares every input; only its pin selection and upper bus enables are watched
   lbw_local_bus #(.NO_INTERNAL_ROM(1'b1)) lbw_local_bus_inst_romless (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(), .cpu_req(cpu_req),
      .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
      .cpu_internal(cpu_internal), .cpu_rom(cpu_rom), .cpu_done(), .cpu_rdata(),
      .address_strobe(), .read_strobe_n(), .write_strobe_n(),
      .low_multiplexed_bus_in(bus_in), .low_multiplexed_bus_out(),
      .low_multiplexed_bus_oe(), .upper_address_lines(),
      .upper_address_bus_en(romless_bus_en), .port_pins_bus_sel(romless_bus_sel),
      .wait_pin_n(wait_pin_n));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts pin activity of one access, sampled mid-cycle where outputs are settled
   task automatic cpu(input logic wr, input logic intl, input logic [19:0] a,
      input logic [7:0] d);
      @(posedge pclk);
      cpu_req <= 1'b1;
      cpu_write <= wr;
      cpu_internal <= intl;
      cpu_addr <= a;
      cpu_wdata <= d;
      n_addr_stb = 0;
      n_low = 0;
      n_oe = 0;
      n_cyc = 0;
      do begin
         @(negedge pclk);
         n_cyc++;
         n_addr_stb += address_strobe;
         n_low += !(read_strobe_n && write_strobe_n);
         n_oe += bus_oe;
         if (address_strobe) up_seen = upper_address_lines;
      end while (cpu_done !== 1'b1);
      rd = {24'h0, cpu_rdata};
      @(posedge pclk);
      cpu_req <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_reset();
      apb(0, LBW_OFF_EXT_CTRL, 0, 0);
      chk(rd, 32'h20);
      apb(0, LBW_OFF_WAIT_LOW, 0, 0);
      chk(rd, 32'hAA);
      apb(0, LBW_OFF_WAIT_HIGH, 0, 0);
      chk(rd, 32'hAAAA);
      apb(0, 12'h00C, 0, 0);
      chk({31'h0, err}, 1);
      chk(port_pins_bus_sel, 0);
      chk(upper_address_bus_en, 0);
      chk(romless_bus_sel, 1);
      chk(romless_bus_en, 12'h0FF);
      $display("test reset done");
   endtask
   task automatic t_regs();
      apb(1, LBW_OFF_WAIT_HIGH, 32'hAA55, 4'h1);
      chk({31'h0, err}, 1);
      apb(0, LBW_OFF_WAIT_HIGH, 0, 0);
      chk(rd, 32'hAAAA);
      apb(1, LBW_OFF_WAIT_HIGH, 32'hAA55, 4'h3); // upper byte kept at the fixed pattern
      apb(0, LBW_OFF_WAIT_HIGH, 0, 0);
      chk(rd, 32'hAA55);
      apb(1, LBW_OFF_WAIT_LOW, 32'h1B, 4'h1);
      apb(0, LBW_OFF_WAIT_LOW, 0, 0);
      chk(rd, 32'h1B);
      apb(1, LBW_OFF_EXT_CTRL, 32'h29, 4'h1);
      apb(0, LBW_OFF_EXT_CTRL, 0, 0);
      chk(rd, 32'h29);
      chk(port_pins_bus_sel, 1);
      chk(upper_address_bus_en, 12'hFFF);
      $display("test registers done");
   endtask
   task automatic t_waits();
      for (int adw = 0; adw < 2; adw++) begin
         for (int w = 0; w < 3; w++) begin
            apb(1, LBW_OFF_EXT_CTRL, 32'h09 | (adw << 5), 4'h1);
            apb(1, LBW_OFF_WAIT_LOW, 32'h8A | (w << 4), 4'h1);
            cpu(0, 0, 20'h08044 + w, 0);
            chk(n_addr_stb, 1 + adw);
            chk(n_low, 1 + w);
            chk(n_cyc, 4 + adw + w);
            chk(rd, (8'h44 + w) ^ 8'h5A);
            chk(up_seen, 12'h080);
         end
      end
      cpu(1, 0, 20'h08033, 8'hC3);
      chk(lbw_ext_mem_inst.mem[8'h33], 8'hC3);
      chk(n_low, 3);
      apb(1, LBW_OFF_WAIT_LOW, 32'h8A, 4'h1);
      cpu(1, 0, 20'h08034, 8'h3C);
      chk(lbw_ext_mem_inst.mem[8'h34], 8'h3C);
      chk(n_low, 1);
      apb(1, LBW_OFF_WAIT_HIGH, 32'hAA9A, 4'h3);
      cpu(0, 0, 20'h41234, 0);
      chk(n_low, 2);
      $display("test waits done");
   endtask
   task automatic t_modes();
      logic [3:0] md [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
      logic [11:0] en [7] = '{12'h000, 12'h003, 12'h00F, 12'h03F, 12'h0FF, 12'h3FF, 12'hFFF};
      for (int i = 0; i < 7; i++) begin
         apb(1, LBW_OFF_EXT_CTRL, {28'h0, md[i]}, 4'h1);
         cpu(0, 0, 20'h54321, 0);
         chk(upper_address_bus_en, en[i]);
         chk(up_seen, 12'h543 & en[i]);
         chk(rd, 8'h21 ^ 8'h5A);
      end
      // internal hit: no pin activity, address left where it was
      cpu(0, 1, 20'h0F200, 0);
      chk(n_addr_stb + n_low + n_oe, 0);
      chk(upper_address_lines, 12'h543);
      // rom on the slow cycle: full timing with two waits, nothing on the pins
      cpu_rom <= 1'b1;
      cpu(0, 1, 20'h01000, 0);
      cpu_rom <= 1'b0;
      chk(n_addr_stb + n_low + n_oe, 0);
      chk(n_cyc, 6);
      chk(upper_address_lines, 12'h543);
      $display("test modes done");
   endtask
   task automatic t_waitpin();
      apb(1, LBW_OFF_WAIT_LOW, 32'hBA, 4'h1); // pin wait only on an external space
      hold_cycles <= 4'h6;
      cpu(0, 0, 20'h08010, 0);
      chk(n_low > 6, 1);
      chk(rd, 8'h10 ^ 8'h5A);
      hold_cycles <= 4'h0;
      $display("test wait pin done");
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // a hung handshake ends the run here
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_waits();
      t_modes();
      t_waitpin();
      tally_and_finish();
   end
endmodule // lbw_local_bus_bench
